// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failCount++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top
  import tws_pkg::*;
;
  // serial clock period in main clocks: one tick every 8 cycles
  localparam int SCKP = 16;
  logic clock, rst_b, tm2Tick, tclTick, mainClkHalf, chan2Async, busyIn, lsbFirst;
  logic sckOut, sckOe, siClaimed, soOut, soOe, strobeOut, irq, siLine, sckGen;
  logic [7:0] busRdata, peerTx, peerRx, d;
  logic [2:0] tickQ;
  tws_busreq_t busReq;
  int failCount = 0;
  int checked = 0;
  wire logic sckLine = sckOe ? sckOut : sckGen;
  wire logic soLine = soOe ? soOut : ~soOut;
  tws_serial1 tws_serial1_i (.clock(clock), .rst_b(rst_b), .busReq(busReq),
    .busRdata(busRdata), .tm2Tick(tm2Tick), .tclTick(tclTick), .mainClkHalf(mainClkHalf),
    .chan2Async(chan2Async), .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe), .siIn(siLine),
    .siClaimed(siClaimed), .soOut(soOut), .soOe(soOe), .busyIn(busyIn),
    .strobeOut(strobeOut), .irq(irq));
  tws_peer_model tws_peer_model_i (.sckLine(sckLine), .soLine(soLine), .lsbFirst(lsbFirst),
    .txByte(peerTx), .siLine(siLine), .rxByte(peerRx), .sckGen(sckGen));
  always #5 clock = ~clock;
  // tm2 and tcl ticks never coincide, so a wrong source shows
  always @(posedge clock) begin
    tickQ <= tickQ + 3'h1;
    tm2Tick <= tickQ == 3'h7;
    tclTick <= tickQ == 3'h3;
  end
  // ------------------------------
  // bus and helpers
  // ------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    @(negedge clock);
    d = busRdata;
    @(posedge clock);
  endtask
  task automatic wait_irq();
    for (int n = 0; irq !== 1'b1; n++) begin
      @(posedge clock);
      if (n > 4000) begin
        failCount++;
        finish_test();
      end
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic reg_test();
    rd(MODE_OFF);
    `CHK(d, MODE_RST)
    rd(INTV_OFF);
    `CHK(d, INTV_RST)
    rd(16'hff6a);
    `CHK(d, 8'h00)
    wr(CTRL_OFF, 8'hff);
    rd(CTRL_OFF);
    `CHK(d, CTRL_WMASK)
    wr(INTV_OFF, 8'h9f);
    rd(INTV_OFF);
    `CHK(d, INTV_WMASK)
    wr(CTRL_OFF, 8'h00);
  endtask
  task automatic plain_xfer(input logic [7:0] mode, input logic [7:0] tx, input logic [7:0] rx);
    lsbFirst <= mode[MODE_LSB_FIRST];
    peerTx <= rx;
    wr(MODE_OFF, mode);
    wr(STAT_OFF, 8'h07);
    wr(MASK_OFF, 8'h01);
    wr(TXD_OFF, tx);
    if (!mode[MODE_CLK_HI]) begin
      tws_peer_model_i.burst();
    end
    wait_irq();
    `CHK(peerRx, tx)
    rd(RXD_OFF);
    `CHK(d, rx)
    wr(MASK_OFF, 8'h00);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    wr(MASK_OFF, 8'h01);
    wr(STAT_OFF, 8'h01);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
  endtask
  task automatic auto_gap(input logic [7:0] intv, input logic [7:0] ctrl, input int f);
    int n, lo, hi, rises, gap;
    logic prev, sawStrobe;
    n = int'(intv[4:0]);
    lo = intv[INTV_ENABLE] ? ((n + 1) * 64 + 28) * f + SCKP / 2 : 2 * SCKP;
    hi = intv[INTV_ENABLE] ? ((n + 1) * 64 + 36) * f + SCKP * 3 / 2 : 1000;
    mainClkHalf <= f == 2;
    lsbFirst <= 1'b0;
    wr(MODE_OFF, 8'h86);
    wr(CTRL_OFF, ctrl);
    wr(INTV_OFF, intv);
    wr(BIDX_OFF, 8'h00);
    wr(BDAT_OFF, 8'h11);
    wr(BDAT_OFF, 8'h22);
    wr(BIDX_OFF, 8'h00);
    wr(STAT_OFF, 8'h07);
    wr(MASK_OFF, 8'h02);
    wr(LAST_OFF, 8'h01);
    rises = 0;
    gap = 0;
    sawStrobe = 1'b0;
    prev = sckOut;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clock);
      #1;
      sawStrobe |= strobeOut;
      if (sckOut && !prev) rises++;
      if (!sckOut && prev && rises == 8) break;
      if (rises == 8) gap++;
      prev = sckOut;
    end
    `CHK(gap >= lo && gap <= hi, 1'b1)
    `CHK(sawStrobe, ctrl[CTRL_STROBE] && !chan2Async)
    wait_irq();
    rd(CTRL_OFF);
    `CHK(d[CTRL_DONE], 1'b1)
    `CHK(peerRx, 8'h22)
  endtask
  initial begin
    {clock, rst_b, tm2Tick, tclTick, mainClkHalf, chan2Async, busyIn, lsbFirst} = 8'h00;
    tickQ = 3'h0;
    busReq = '0;
    peerTx = 8'h00;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    reg_test();
    plain_xfer(8'h82, 8'ha5, 8'h3c);
    plain_xfer(8'h8b, 8'h96, 8'h61);
    plain_xfer(8'h89, 8'h5a, 8'hc3);
    busyIn <= 1'b1;
    auto_gap(8'h80, 8'h82, 1);
    chan2Async <= 1'b1;
    auto_gap(8'h81, 8'h04, 2);
    chan2Async <= 1'b0;
    busyIn <= 1'b0;
    auto_gap(8'h00, 8'h84, 1);
    wr(MODE_OFF, 8'h00);
    repeat (4) @(posedge clock);
    finish_test();
  end
endmodule
bind tws_serial1 tws_serial1_checker tws_serial1_checker_i (.clock(clock), .rst_b(rst_b),
  .busReq(busReq), .tm2Tick(tm2Tick), .tclTick(tclTick), .chan2Async(chan2Async),
  .sckOut(sckOut), .sckOe(sckOe), .siClaimed(siClaimed), .soOe(soOe), .strobeOut(strobeOut));
`default_nettype wire

// *** tws_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tws_peer_model (
  input wire logic sckLine,
  input wire logic soLine,
  input wire logic lsbFirst,
  input wire logic [7:0] txByte,
  output logic siLine,
  output logic [7:0] rxByte,
  output logic sckGen
);
  int bitNo;
  logic armed;
  initial begin
    bitNo = 0;
    armed = 1'b0;
    siLine = 1'b1;
    rxByte = 8'h00;
    sckGen = 1'b1;
  end
  always @(negedge sckLine) begin
    armed = 1'b1;
    siLine = lsbFirst ? txByte[bitNo] : txByte[7 - bitNo];
  end
  // a rise out of the unknown power-up level is no clock edge
  always @(posedge sckLine) begin
    if (armed) begin
      rxByte = lsbFirst ? {soLine, rxByte[7:1]} : {rxByte[6:0], soLine};
      bitNo = (bitNo + 1) % 8;
      // hold time over after a byte: stop showing the last bit
      if (bitNo == 0) begin
        siLine <= #100 ~siLine;
      end
    end
  end
  // clock stands high outside frames
  task automatic burst();
    // keep pin edges off the sampling edge
    #3;
    repeat (8) begin
      #200 sckGen = 1'b0;
      #200 sckGen = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// *** tws_pkg.sv ***
package tws_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] MODE_OFF = 16'hff68;
  localparam logic [15:0] CTRL_OFF = 16'hff69;
  localparam logic [15:0] INTV_OFF = 16'hff6b;
  localparam logic [15:0] TXD_OFF = 16'hff6c;
  localparam logic [15:0] RXD_OFF = 16'hff6d;
  localparam logic [15:0] BIDX_OFF = 16'hff6e;
  localparam logic [15:0] BDAT_OFF = 16'hff6f;
  localparam logic [15:0] LAST_OFF = 16'hff70;
  localparam logic [15:0] STAT_OFF = 16'hff71;
  localparam logic [15:0] MASK_OFF = 16'hff72;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_ENABLE = 7;
  localparam int MODE_LSB_FIRST = 3;
  localparam int MODE_AUTO = 2;
  localparam int MODE_CLK_HI = 1;
  localparam int CTRL_RX_ALLOW = 7;
  localparam int CTRL_ERROR = 4;
  localparam int CTRL_DONE = 3;
  localparam int CTRL_STROBE = 2;
  localparam int CTRL_WAIT = 1;
  localparam int INTV_ENABLE = 7;
  localparam int STAT_BYTE = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERROR = 2;

  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] INTV_RST = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h8f;
  localparam logic [7:0] CTRL_WMASK = 8'h86;
  localparam logic [7:0] INTV_WMASK = 8'h9f;

  // ------------------------------------------------------------
  // counts, in fxx periods unless noted; buffer depth in entries
  // ------------------------------------------------------------
  localparam int BUF_DEPTH = 32;
  localparam logic [11:0] GAP_STEP = 12'h040;
  localparam logic [11:0] GAP_EXTRA_MIN = 12'h01c;
  localparam logic [11:0] GAP_EXTRA_MAX = 12'h024;
  localparam logic [11:0] GAP_EXTRA = 12'((GAP_EXTRA_MIN + GAP_EXTRA_MAX) / 2);
  // two serial clock periods, counted in half periods
  localparam logic [2:0] GAP_MIN_HALVES = 3'h4;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tws_busreq_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_GAP
  } tws_state_t;

endpackage

// *** tws_serial1.sv ***
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - clock select picks pin, timer2 or tcl
// - auto bit chooses plain or auto transfer
// - bit order bit picks msb or lsb
// - disabled: shifter stopped, counter cleared, pins released
// - no receive in auto: input pin released
// - done and error flags read-only
// - shared-pin async mode disables wait/strobe
// - interval enable selects timed gaps
// - gap within (n+1)*64+28..36 fxx periods
// - gap never below two serial periods
// - timed gap ignores the busy handshake
// - gap timing counts fxx ticks, fx or fx/2
module tws_serial1
  import tws_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire tws_busreq_t busReq,
  output logic [7:0] busRdata,
  input wire logic tm2Tick,
  input wire logic tclTick,
  input wire logic mainClkHalf,
  input wire logic chan2Async,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic siIn,
  output logic siClaimed,
  output logic soOut,
  output logic soOe,
  input wire logic busyIn,
  output logic strobeOut,
  output logic irq
);

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] mode_q, ctrl_q, intv_q, txd_q, rxd_q, last_q, stat_q, mask_q;
  logic [4:0] bidx_q;
  logic [7:0] buf_q [BUF_DEPTH];
  logic doneSet, errSet, byteSet, autoStart, plainStart;
  logic enable, autoMode, lsbFirst, internalClk, rxAllow, waitCtl, strobeCtl;

  assign enable = mode_q[MODE_ENABLE];
  assign autoMode = mode_q[MODE_AUTO];
  assign lsbFirst = mode_q[MODE_LSB_FIRST];
  assign internalClk = mode_q[MODE_CLK_HI];
  assign rxAllow = ctrl_q[CTRL_RX_ALLOW];
  // shared pins busy in async mode
  assign waitCtl = ctrl_q[CTRL_WAIT] && !chan2Async;
  assign strobeCtl = ctrl_q[CTRL_STROBE] && !chan2Async;

  assign plainStart = busReq.wr && hit(busReq.addr, TXD_OFF) && enable && !autoMode;
  assign autoStart = busReq.wr && hit(busReq.addr, LAST_OFF) && enable && autoMode;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_RST;
      intv_q <= INTV_RST;
      txd_q <= 8'h00;
      last_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (busReq.wr) begin
      if (hit(busReq.addr, MODE_OFF)) mode_q <= busReq.wdata & MODE_WMASK;
      if (hit(busReq.addr, INTV_OFF)) intv_q <= busReq.wdata & INTV_WMASK;
      if (hit(busReq.addr, TXD_OFF)) txd_q <= busReq.wdata;
      if (hit(busReq.addr, LAST_OFF)) last_q <= {3'h0, busReq.wdata[4:0]};
      if (hit(busReq.addr, MASK_OFF)) mask_q <= busReq.wdata & 8'h07;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (busReq.wr && hit(busReq.addr, CTRL_OFF)) begin
        ctrl_q[7:5] <= busReq.wdata[7:5] & CTRL_WMASK[7:5];
        ctrl_q[2:0] <= busReq.wdata[2:0] & CTRL_WMASK[2:0];
      end
      if (doneSet) ctrl_q[CTRL_DONE] <= 1'b1;
      else if (autoStart) ctrl_q[CTRL_DONE] <= 1'b0;
      if (errSet) ctrl_q[CTRL_ERROR] <= 1'b1;
      else if (autoStart) ctrl_q[CTRL_ERROR] <= 1'b0;
    end
  end

  // status: write one clears, a new event wins over the clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == STAT_BYTE && byteSet) || (i == STAT_DONE && doneSet) ||
            (i == STAT_ERROR && errSet)) begin
          stat_q[i] <= 1'b1;
        end else if (busReq.wr && hit(busReq.addr, STAT_OFF) && busReq.wdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) irq <= 1'b0;
    else irq <= |(stat_q & mask_q);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busRdata <= 8'h00;
    end else if (busReq.rd) begin
      case (busReq.addr)
        MODE_OFF: busRdata <= mode_q;
        CTRL_OFF: busRdata <= ctrl_q;
        INTV_OFF: busRdata <= intv_q;
        TXD_OFF: busRdata <= txd_q;
        RXD_OFF: busRdata <= rxd_q;
        BIDX_OFF: busRdata <= {3'h0, bidx_q};
        BDAT_OFF: busRdata <= buf_q[bidx_q];
        LAST_OFF: busRdata <= last_q;
        STAT_OFF: busRdata <= stat_q;
        MASK_OFF: busRdata <= mask_q;
        default: busRdata <= 8'h00;
      endcase
    end else begin
      busRdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_q, sync2_q, sync3_q, pinStable_q;
  logic sckFallExt, sckRiseExt, siLvl, busyLvl;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      sync3_q <= 3'h7;
      pinStable_q <= 3'h7;
    end else begin
      sync1_q <= {busyIn, siIn, sckIn};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 3; i++) begin
        if (sync2_q[i] == sync3_q[i]) pinStable_q[i] <= sync3_q[i];
      end
    end
  end

  assign sckFallExt = pinStable_q[0] && sync2_q[0] == sync3_q[0] && !sync3_q[0];
  assign sckRiseExt = !pinStable_q[0] && sync2_q[0] == sync3_q[0] && sync3_q[0];
  assign siLvl = pinStable_q[1];
  assign busyLvl = pinStable_q[2];

  // ------------------------------------------------------------
  // serial clock and fxx tick
  // ------------------------------------------------------------
  logic srcTick, sckLvl_q, sckFall, sckRise, fxxPhase_q, fxxTick;
  tws_state_t state_q;

  assign srcTick = mode_q[0] ? tclTick : tm2Tick;
  assign sckFall = internalClk ? (srcTick && sckLvl_q && state_q == ST_SHIFT) : sckFallExt;
  assign sckRise = internalClk ? (srcTick && !sckLvl_q && state_q == ST_SHIFT) : sckRiseExt;

  // fxx is the main clock or half of it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) fxxPhase_q <= 1'b0;
    else fxxPhase_q <= !fxxPhase_q;
  end
  assign fxxTick = mainClkHalf ? fxxPhase_q : 1'b1;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sckLvl_q <= 1'b1;
    else if (!enable || state_q != ST_SHIFT) sckLvl_q <= 1'b1;
    else if (internalClk && srcTick) sckLvl_q <= !sckLvl_q;
  end

  // ------------------------------------------------------------
  // shift engine
  // ------------------------------------------------------------
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q, gapHalves_q;
  logic [4:0] ptr_q;
  logic [11:0] gapCnt_q, gapTarget;
  logic byteEnd, gapTimeOk, gapDone, rxOn;

  // receive off in auto mode frees input
  assign rxOn = !autoMode || rxAllow;
  assign byteEnd = state_q == ST_SHIFT && sckRise && bitCnt_q == 3'h7;
  assign gapTarget = 12'(({7'h00, intv_q[4:0]} + 12'h001) * GAP_STEP) + GAP_EXTRA;
  assign gapTimeOk = !intv_q[INTV_ENABLE] || gapCnt_q >= gapTarget;
  // at least two serial periods; busy ignored when timed
  assign gapDone = gapTimeOk && gapHalves_q >= GAP_MIN_HALVES &&
                   (intv_q[INTV_ENABLE] || !waitCtl || !busyLvl);
  assign byteSet = byteEnd;
  assign doneSet = byteEnd && autoMode && ptr_q == last_q[4:0];
  assign errSet = !enable && state_q != ST_IDLE && autoMode;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      ptr_q <= 5'h00;
    end else if (!enable) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (plainStart) state_q <= ST_SHIFT;
          if (autoStart) begin
            ptr_q <= 5'h00;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (byteEnd) state_q <= (!autoMode || doneSet) ? ST_IDLE : ST_GAP;
        end
        ST_GAP: begin
          if (gapDone) begin
            ptr_q <= ptr_q + 5'h01;
            state_q <= ST_SHIFT;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gapCnt_q <= 12'h000;
      gapHalves_q <= 3'h0;
    end else if (state_q != ST_GAP) begin
      gapCnt_q <= 12'h000;
      gapHalves_q <= 3'h0;
    end else begin
      if (fxxTick && gapCnt_q != 12'hfff) gapCnt_q <= gapCnt_q + 12'h001;
      if ((internalClk ? srcTick : (sckFallExt || sckRiseExt)) && gapHalves_q != 3'h7) begin
        gapHalves_q <= gapHalves_q + 3'h1;
      end
    end
  end

  // disabled clears the bit counter; counts serial clock rises while shifting
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) bitCnt_q <= 3'h0;
    else if (!enable || state_q != ST_SHIFT) bitCnt_q <= 3'h0;
    else if (sckRise) bitCnt_q <= bitCnt_q + 3'h1;
  end

  // bit order; data out on fall, sampled on rise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 8'h00;
      soOut <= 1'b1;
    end else if (enable) begin
      if (state_q == ST_IDLE && plainStart) shift_q <= busReq.wdata;
      else if (state_q == ST_IDLE && autoStart) shift_q <= buf_q[0];
      else if (state_q == ST_GAP && gapDone) shift_q <= buf_q[ptr_q + 5'h01];
      else if (state_q == ST_SHIFT && sckRise) begin
        if (lsbFirst) shift_q <= {siLvl && rxOn, shift_q[7:1]};
        else shift_q <= {shift_q[6:0], siLvl && rxOn};
      end
      if (state_q == ST_SHIFT && sckFall) soOut <= lsbFirst ? shift_q[0] : shift_q[7];
    end
  end

  logic [7:0] rxByte;
  assign rxByte = lsbFirst ? {siLvl && rxOn, shift_q[7:1]} : {shift_q[6:0], siLvl && rxOn};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rxd_q <= 8'h00;
    else if (byteEnd) rxd_q <= rxByte;
  end

  // buffer: engine store wins over a software store in one cycle
  always_ff @(posedge clock) begin
    if (byteEnd && autoMode && rxAllow) buf_q[ptr_q] <= rxByte;
    else if (busReq.wr && hit(busReq.addr, BDAT_OFF)) buf_q[bidx_q] <= busReq.wdata;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) bidx_q <= 5'h00;
    else if (busReq.wr && hit(busReq.addr, BIDX_OFF)) bidx_q <= busReq.wdata[4:0];
    else if ((busReq.wr || busReq.rd) && hit(busReq.addr, BDAT_OFF)) bidx_q <= bidx_q + 5'h01;
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sckOut <= 1'b1;
      sckOe <= 1'b0;
      soOe <= 1'b0;
      siClaimed <= 1'b0;
      strobeOut <= 1'b0;
    end else begin
      sckOut <= sckLvl_q;
      // released when disabled; output only for internal clock
      sckOe <= enable && internalClk;
      soOe <= enable;
      // input pin free when receive is off
      siClaimed <= enable && rxOn;
      // strobe only when pins are ours
      strobeOut <= strobeCtl && enable && state_q == ST_GAP && gapHalves_q < 3'h2;
    end
  end

endmodule

`default_nettype wire

// *** tws_serial1_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tws_serial1_checker
  import tws_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire tws_busreq_t busReq,
  input wire logic tm2Tick,
  input wire logic tclTick,
  input wire logic chan2Async,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic siClaimed,
  input wire logic soOe,
  input wire logic strobeOut
);
  logic [7:0] modeQ;
  logic [7:0] ctrlQ;
  logic [1:0] calmQ;
  wire logic calm = calmQ == 2'h3;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ------------------------------
  // mirror of software settings
  // ------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      modeQ <= 8'h00;
      ctrlQ <= 8'h00;
    end else if (busReq.wr && busReq.addr == MODE_OFF) begin
      modeQ <= busReq.wdata;
    end else if (busReq.wr && busReq.addr == CTRL_OFF) begin
      ctrlQ <= busReq.wdata;
    end
  end
  // pins are registered, so judge them only once writes have settled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      calmQ <= 2'h0;
    end else if (busReq.wr) begin
      calmQ <= 2'h0;
    end else if (!calm) begin
      calmQ <= calmQ + 2'h1;
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  // pins let go
  pins_release_a: assert property (calm && !modeQ[7] |-> !sckOe && !soOe && !siClaimed)
    else $error("pins driven while disabled");
  ext_clk_in_a: assert property (calm && modeQ[7] && !modeQ[1] |-> !sckOe)
    else $error("clock pin driven with external clock");
  int_clk_out_a: assert property (calm && modeQ[7] && modeQ[1] |-> sckOe && soOe)
    else $error("clock or data pin not driven");
  si_free_a: assert property (calm && modeQ[7] && modeQ[2] && !ctrlQ[7] |-> !siClaimed)
    else $error("data input held without receive");
  si_claim_a: assert property (calm && modeQ[7] && !modeQ[2] |-> siClaimed)
    else $error("data input not used in plain mode");
  tm2_select_a: assert property (calm && modeQ[7] && modeQ[1:0] == 2'b10 && $changed(sckOut)
    |-> $past(tm2Tick) || $past(tm2Tick, 2))
    else $error("clock moved without timer2 tick");
  tcl_select_a: assert property (calm && modeQ[7] && modeQ[1:0] == 2'b11 && $changed(sckOut)
    |-> $past(tclTick) || $past(tclTick, 2))
    else $error("clock moved without tcl tick");
  strobe_off_a: assert property (chan2Async && $past(chan2Async) |-> !strobeOut)
    else $error("strobe while pins shared");
endmodule
`default_nettype wire
